// [trmsq_top.sv]
// Operation
// - Selecting the ac-plus-dc function enters fast mode.
// - Mode key steps fast, fast enhanced, high accuracy, then fast again.
// - Function selection starts autoranging unless manual ranging is chosen.
// - Mode stepping leaves the present range untouched.
// - Eight ranges from 500 V down to 100 mV.
// - Each autoranged range is shown on the display as it is chosen, unless a mode banner is up.
// - Fast mode shows a reading within half a second.
// - Fast mode: ac and dc lamps lit, no sign, sample lamp twice a second.
// - Fast enhanced banner stays while the reference measurement runs.
// - First corrected reading within half a second, then every half second.
// - Fast enhanced readings carry a plus sign.
// - High accuracy banner during the first six-second measurement.
// - High accuracy reading appears at cycle end, then every six seconds.
// - High accuracy: sample lamp toggles per six-second cycle, no sign.
// - Current functions are refused.
// - First reading measured while the sample/hold tracks the sensor output.
// - First reading is doubled and kept.
// - After the first reading the held sample feeds the sensor.
// - Result is the doubled value minus the second reading.
// - Range drives attenuator and ranging amplifier.
// - High accuracy repeats 3.5 s sample then 2.5 s hold.
// - Fast enhanced re-references on range, filter or one-percent drift.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "trmsq_defines.svh"

module trmsq_top
#(
  parameter int DW         = 16,
  parameter int READ_CYC   = `TRMSQ_READ_MS * `TRMSQ_CLK_KHZ,
  parameter int SAMPLE_CYC = `TRMSQ_SAMPLE_MS * `TRMSQ_CLK_KHZ,
  parameter int HOLD_CYC   = `TRMSQ_HOLD_MS * `TRMSQ_CLK_KHZ
)
(
  input  wire logic                      clk_i,
  input  wire logic                      nrst_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [11:0]               paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic      [31:0]               prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  input  wire logic                      mode_key_i,
  input  wire logic [DW-1:0]             adc_data_i,
  input  wire logic                      adc_over_i,
  input  wire logic                      adc_under_i,
  output logic      [2:0]                range_o,
  output logic                           hold_o,
  output logic                           sh_feed_o,
  output trmsq_pkg::trmsq_disp_type      disp_msg_o,
  output logic      [DW-1:0]             disp_value_o,
  output logic                           disp_plus_o,
  output logic                           sample_ind_o,
  output logic                           ac_volts_function_o,
  output logic                           dc_volts_function_o
);

  import trmsq_pkg::*;

  localparam int TW = 28;

  logic                 ac_sel;
  logic                 dc_sel;
  logic                 manual;
  logic                 filter;
  logic                 refused;
  logic [2:0]           man_range;
  trmsq_mode_type       mode;
  trmsq_mode_type       next_mode;
  trmsq_phase_type      phase;
  trmsq_phase_type      next_phase;
  logic                 key_q;
  logic                 func_q;
  logic                 filt_q;
  logic [DW:0]          y1x2;
  logic [DW-1:0]        ref_y1;
  logic signed [DW+1:0] corr;
  logic                 func_on;
  logic                 func_rise;
  logic                 key_press;
  logic                 tmr_done;
  logic                 meas_done;
  logic                 auto_up;
  logic                 auto_dn;
  logic                 range_chg;
  logic                 filt_chg;
  logic                 reref;
  logic                 ld;
  logic [TW-1:0]        ld_val;
  logic [DW-1:0]        result;
  logic [DW-1:0]        tracked;
  logic                 apb_first;
  logic                 apb_wr;
  logic [31:0]          rd_data;
  logic                 rd_hit;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Clamp a signed sum into the display range
  function automatic logic [DW-1:0] trmsq_sat(input logic signed [DW+1:0] v);
    if (v < 0)
      trmsq_sat = '0;
    else if (v > $signed({2'b00, {DW{1'b1}}}))
      trmsq_sat = {DW{1'b1}};
    else
      trmsq_sat = v[DW-1:0];
  endfunction

  // True when a reading strays one percent or more from the reference
  function automatic logic trmsq_off_lim(input logic [DW-1:0] r, input logic [DW-1:0] ref_v);
    logic [DW-1:0] d;
    logic [DW+6:0] p;
    d = (r >= ref_v) ? r - ref_v : ref_v - r;
    p = {7'h00, d} * (DW+7)'(`TRMSQ_PCT_SCALE);
    trmsq_off_lim = (p >= {7'h00, ref_v});
  endfunction

  // Period to load for each phase
  function automatic logic [TW-1:0] trmsq_cyc(input trmsq_phase_type p);
    case (p)
      ph_samp: trmsq_cyc = TW'(SAMPLE_CYC);
      ph_hold: trmsq_cyc = TW'(HOLD_CYC);
      default: trmsq_cyc = TW'(READ_CYC);
    endcase
  endfunction

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  // The function is the ac and dc selections made together
  assign func_on   = ac_sel & dc_sel;
  assign func_rise = func_on & ~func_q;
  assign key_press = func_on & mode_key_i & ~key_q;
  assign meas_done = func_on & tmr_done & (phase != ph_off);
  assign auto_up   = meas_done & ~manual & ~key_press & adc_over_i & (range_o != `TRMSQ_RNG_MAX);
  assign auto_dn   = meas_done & ~manual & ~key_press & adc_under_i & (range_o != `TRMSQ_RNG_MIN);
  assign range_chg = auto_up | auto_dn | (func_on & manual & (man_range != range_o));
  assign filt_chg  = func_on & (filter != filt_q);
  assign reref     = meas_done & (phase == ph_track) & trmsq_off_lim(adc_data_i, ref_y1);

  // Transfer result: twice the first reading less the second
  assign result  = trmsq_sat($signed({1'b0, y1x2}) - $signed({2'b00, adc_data_i}));
  // Fast reading shifted by the stored correction
  assign tracked = trmsq_sat($signed({2'b00, adc_data_i}) + corr);

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // One wait state so that read data comes from a flip-flop
  assign apb_first = psel_i & penable_i & ~pready_o;
  assign apb_wr    = psel_i & penable_i & pready_o & pwrite_i;

  // Read decode
  always_comb
  begin
    rd_data = 32'h0;
    rd_hit  = 1'b1;
    if (paddr_i == `TRMSQ_CTRL_ADDR)
    begin
      rd_data[`TRMSQ_C_AC]   = ac_sel;
      rd_data[`TRMSQ_C_DC]   = dc_sel;
      rd_data[`TRMSQ_C_MAN]  = manual;
      rd_data[`TRMSQ_C_RNG]  = man_range;
      rd_data[`TRMSQ_C_FILT] = filter;
    end
    else if (paddr_i == `TRMSQ_STAT_ADDR)
    begin
      rd_data[`TRMSQ_S_REF]   = refused;
      rd_data[`TRMSQ_S_MODE]  = mode;
      rd_data[`TRMSQ_S_PHASE] = phase;
      rd_data[`TRMSQ_S_RNG]   = range_o;
    end
    else if (paddr_i == `TRMSQ_RES_ADDR)
      rd_data[DW-1:0] = disp_value_o;
    else
      rd_hit = 1'b0;
  end

  // Handshake and registered read data
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o  <= apb_first;
      pslverr_o <= apb_first & ~rd_hit;
      if (apb_first)
        prdata_o <= rd_data;
    end
  end

  // Control register; current functions never reach the fields
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ac_sel    <= 1'b0;
      dc_sel    <= 1'b0;
      manual    <= 1'b0;
      man_range <= `TRMSQ_RNG_MAX;
      filter    <= 1'b0;
      refused   <= 1'b0;
    end
    else
    begin
      if (apb_wr && paddr_i == `TRMSQ_STAT_ADDR && pwdata_i[`TRMSQ_S_REF])
        refused <= 1'b0;
      if (apb_wr && paddr_i == `TRMSQ_CTRL_ADDR)
      begin
        if (pwdata_i[`TRMSQ_C_ACI] || pwdata_i[`TRMSQ_C_DCI])
          refused <= 1'b1;
        else
        begin
          ac_sel    <= pwdata_i[`TRMSQ_C_AC];
          dc_sel    <= pwdata_i[`TRMSQ_C_DC];
          manual    <= pwdata_i[`TRMSQ_C_MAN];
          man_range <= pwdata_i[`TRMSQ_C_RNG];
          filter    <= pwdata_i[`TRMSQ_C_FILT];
        end
      end
    end
  end

  // ----------------------------------------
  // Mode sequencing
  // ----------------------------------------
  // Edge memories for key, function and filter
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      key_q  <= 1'b0;
      func_q <= 1'b0;
      filt_q <= 1'b0;
    end
    else
    begin
      key_q  <= mode_key_i;
      func_q <= func_on;
      filt_q <= filter;
    end
  end

  // Mode cycle; the spare code falls back to fast
  always_comb
  begin
    case (mode)
      mode_fast:  next_mode = mode_faste;
      mode_faste: next_mode = mode_prec;
      default:    next_mode = mode_fast;
    endcase
  end

  // Mode register
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      mode <= mode_fast;
    else if (func_rise)
      mode <= mode_fast;
    else if (key_press)
      mode <= next_mode;
    else if (!(mode inside {mode_fast, mode_faste, mode_prec}))
      mode <= mode_fast;
  end

  // ----------------------------------------
  // Ranging
  // ----------------------------------------
  // Autorange steps one range per reading; a mode key press never
  // touches the range
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      range_o <= `TRMSQ_RNG_MAX;
    else if (func_rise && !manual)
      range_o <= `TRMSQ_RNG_MAX;
    else if (func_on && manual)
      range_o <= man_range;
    else if (auto_up)
      range_o <= range_o + `TRMSQ_RNG_STEP;
    else if (auto_dn)
      range_o <= range_o - `TRMSQ_RNG_STEP;
  end

  // ----------------------------------------
  // Converter phase control
  // ----------------------------------------
  // Any disturbance restarts the measurement so no reading mixes ranges
  always_comb
  begin
    next_phase = phase;
    ld         = 1'b0;
    if (!func_on)
      next_phase = ph_off;
    else if (func_rise || (key_press && next_mode == mode_fast))
    begin
      next_phase = ph_fast;
      ld         = 1'b1;
    end
    else if (key_press)
    begin
      next_phase = ph_samp;
      ld         = 1'b1;
    end
    else if (range_chg || filt_chg || reref)
    begin
      next_phase = (mode == mode_fast) ? ph_fast : ph_samp;
      ld         = 1'b1;
    end
    else if (meas_done)
    begin
      ld = 1'b1;
      case (phase)
        ph_samp: next_phase = ph_hold;
        ph_hold: next_phase = (mode == mode_prec) ? ph_samp : ph_track;
        default: next_phase = phase;
      endcase
    end
    ld_val = trmsq_cyc(next_phase);
  end

  trmsq_timer
  #(
    .W (TW)
  )
  u_timer
  (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .load_i  (ld),
    .count_i (ld_val),
    .done_o  (tmr_done)
  );

  // Phase, switch network and stored readings
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      phase     <= ph_off;
      hold_o    <= 1'b0;
      sh_feed_o <= 1'b0;
      y1x2      <= '0;
      ref_y1    <= '0;
      corr      <= '0;
    end
    else
    begin
      phase     <= next_phase;
      // Hold while the held sample drives the sensor
      hold_o    <= (next_phase == ph_hold);
      sh_feed_o <= (next_phase == ph_hold);
      if (meas_done && phase == ph_samp && !range_chg)
      begin
        y1x2   <= {adc_data_i, 1'b0};
        ref_y1 <= adc_data_i;
      end
      if (meas_done && phase == ph_hold && !range_chg)
        corr <= $signed({2'b00, result}) - $signed({2'b00, ref_y1});
    end
  end

  // ----------------------------------------
  // Display and lamps
  // ----------------------------------------
  // Banners outrank range codes until the first reading replaces them
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      disp_msg_o          <= disp_blank;
      disp_value_o        <= '0;
      disp_plus_o         <= 1'b0;
      sample_ind_o        <= 1'b0;
      ac_volts_function_o <= 1'b0;
      dc_volts_function_o <= 1'b0;
    end
    else
    begin
      ac_volts_function_o <= ac_sel;
      dc_volts_function_o <= dc_sel;
      if (!func_on)
      begin
        disp_msg_o  <= disp_blank;
        disp_plus_o <= 1'b0;
      end
      else if (func_rise)
        disp_msg_o <= disp_blank;
      else if (key_press)
      begin
        disp_plus_o <= 1'b0;
        case (next_mode)
          mode_faste: disp_msg_o <= disp_faste_banner;
          mode_prec:  disp_msg_o <= disp_precision_mode_banner;
          default:    disp_msg_o <= disp_read;
        endcase
      end
      else if (range_chg)
      begin
        if (disp_msg_o != disp_faste_banner && disp_msg_o != disp_precision_mode_banner)
          disp_msg_o <= disp_range;
      end
      else if (meas_done)
      begin
        case (phase)
          ph_fast:
          begin
            disp_value_o <= adc_data_i;
            disp_msg_o   <= disp_read;
            disp_plus_o  <= 1'b0;
            sample_ind_o <= ~sample_ind_o;
          end
          ph_hold:
          begin
            if (mode == mode_prec)
            begin
              disp_value_o <= result;
              disp_msg_o   <= disp_read;
              disp_plus_o  <= 1'b0;
              sample_ind_o <= ~sample_ind_o;
            end
          end
          ph_track:
          begin
            if (!reref)
            begin
              disp_value_o <= tracked;
              disp_msg_o   <= disp_read;
              disp_plus_o  <= 1'b1;
              sample_ind_o <= ~sample_ind_o;
            end
          end
          default:
          begin
            disp_plus_o <= disp_plus_o;
          end
        endcase
      end
    end
  end

endmodule

// [trmsq_defines.svh]
`ifndef TRMSQ_DEFINES_SVH
`define TRMSQ_DEFINES_SVH

// ----------------------------------------
// Clock rate and measurement times
// ----------------------------------------
`define TRMSQ_CLK_KHZ    50000
`define TRMSQ_READ_MS    500
`define TRMSQ_SAMPLE_MS  3500
`define TRMSQ_HOLD_MS    2500

// ----------------------------------------
// APB byte offsets
// ----------------------------------------
`define TRMSQ_CTRL_ADDR  12'h000
`define TRMSQ_STAT_ADDR  12'h004
`define TRMSQ_RES_ADDR   12'h008

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define TRMSQ_C_AC       0
`define TRMSQ_C_DC       1
`define TRMSQ_C_ACI      2
`define TRMSQ_C_DCI      3
`define TRMSQ_C_MAN      4
`define TRMSQ_C_RNG      7:5
`define TRMSQ_C_FILT     8

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define TRMSQ_S_REF      0
`define TRMSQ_S_MODE     2:1
`define TRMSQ_S_PHASE    5:3
`define TRMSQ_S_RNG      8:6

// ----------------------------------------
// Ranges: index 0 is 100 mV, index 7 is 500 V
// ----------------------------------------
`define TRMSQ_RNG_MIN    3'h0
`define TRMSQ_RNG_MAX    3'h7
`define TRMSQ_RNG_STEP   3'h1

// Correction drift limit, one part in a hundred
`define TRMSQ_PCT_SCALE  7'h64

`endif

// [trmsq_pkg.sv]
package trmsq_pkg;

  // Measurement mode, held in two bits
  typedef enum logic [1:0]
  {
    mode_fast  = 2'b00,
    mode_faste = 2'b01,
    mode_prec  = 2'b10
  } trmsq_mode_type;

  // Converter cycle phase
  typedef enum logic [2:0]
  {
    ph_off   = 3'b000,
    ph_fast  = 3'b001,
    ph_samp  = 3'b010,
    ph_hold  = 3'b011,
    ph_track = 3'b100
  } trmsq_phase_type;

  // Message shown on the display
  typedef enum logic [2:0]
  {
    disp_blank                 = 3'b000,
    disp_read                  = 3'b001,
    disp_range                 = 3'b010,
    disp_faste_banner          = 3'b011,
    disp_precision_mode_banner = 3'b100
  } trmsq_disp_type;

endpackage

// [trmsq_timer.sv]
`timescale 1ns/10ps

module trmsq_timer
#(
  parameter int W = 28
)
(
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  output logic              done_o
);

  logic [W-1:0] cnt;
  logic         run;

  // ----------------------------------------
  // Down counter, one done pulse per load
  // ----------------------------------------
  // A new load restarts the count, so a range change mid-phase never
  // lets a stale period finish
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt    <= '0;
      run    <= 1'b0;
      done_o <= 1'b0;
    end
    else if (load_i)
    begin
      cnt    <= count_i;
      run    <= 1'b1;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= run && (cnt == W'(1));
      if (run)
      begin
        cnt <= cnt - W'(1);
        run <= (cnt != W'(1));
      end
    end
  end

endmodule

// [trmsq_conv_model.sv]
`timescale 1ns/10ps

module trmsq_conv_model
#(
  parameter int DW = 16
)
(
  input  wire logic [2:0]    range_i,
  input  wire logic          sh_feed_i,
  input  wire logic [2:0]    tgt_i,
  input  wire logic [DW-1:0] y1_i,
  input  wire logic [DW-1:0] y2_i,
  output logic      [DW-1:0] adc_data_o,
  output logic               over_o,
  output logic               under_o
);
  // A range below the signal overloads, one above underreads
  always_comb over_o = range_i < tgt_i;
  always_comb under_o = range_i > tgt_i;
  // Held sample on the sensor yields the second, shifted reading
  always_comb adc_data_o = sh_feed_i ? y2_i : y1_i;
endmodule

// [trmsq_chk.sv]
`timescale 1ns/10ps

module trmsq_chk
(
  input wire logic                      clk_i,
  input wire logic                      nrst_i,
  input wire logic                      psel_i,
  input wire logic                      penable_i,
  input wire logic [11:0]               paddr_i,
  input wire logic                      pready_o,
  input wire logic                      pslverr_o,
  input wire logic                      mode_key_i,
  input wire logic [2:0]                range_o,
  input wire logic                      hold_o,
  input wire logic                      sh_feed_o,
  input wire trmsq_pkg::trmsq_disp_type disp_msg_o,
  input wire logic                      disp_plus_o,
  input wire logic                      sample_ind_o,
  input wire logic                      ac_volts_function_o,
  input wire logic                      dc_volts_function_o
);
  import trmsq_pkg::*;
  // ----------------------------------------
  // Bus and converter checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Both lamps lit means the ac-plus-dc function is on
  wire logic fn_on = ac_volts_function_o && dc_volts_function_o;

  chk_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("pready late");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready too long");
  chk_err_addr: assert property (psel_i && penable_i && pready_o |-> pslverr_o == (paddr_i > 12'h008))
    else $error("pslverr wrong");
  chk_err_only: assert property (pslverr_o |-> pready_o)
    else $error("stray pslverr");
  chk_feed_hold: assert property (hold_o == sh_feed_o)
    else $error("feed not with hold");
  chk_hold_stays: assert property ($rose(hold_o) |-> hold_o [*8])
    else $error("hold cut short");
  chk_lamp_read: assert property ($changed(sample_ind_o) |-> disp_msg_o == disp_read)
    else $error("lamp without reading");
  chk_plus_lamps: assert property (disp_plus_o |-> fn_on)
    else $error("plus without lamps");
  chk_key_range: assert property ($rose(mode_key_i) && fn_on |=> $stable(range_o))
    else $error("range moved on key");
endmodule

bind trmsq_top trmsq_chk u_chk
(
  .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
  .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .mode_key_i(mode_key_i), .range_o(range_o), .hold_o(hold_o),
  .sh_feed_o(sh_feed_o), .disp_msg_o(disp_msg_o), .disp_plus_o(disp_plus_o),
  .sample_ind_o(sample_ind_o), .ac_volts_function_o(ac_volts_function_o),
  .dc_volts_function_o(dc_volts_function_o)
);

// [tb.sv]
`timescale 1ns/10ps

module tb;
  import trmsq_pkg::*;
  localparam int DW = 16;
  localparam int RC = 20;
  localparam int SC = 70;
  localparam int HC = 50;
  logic           clk_i, nrst_i, psel_i, penable_i, pwrite_i, mode_key_i;
  logic           pready_o, pslverr_o, ovr, und, hold_o, feed, plus, ind, ac, dc, ind_q;
  logic [11:0]    paddr_i;
  logic [31:0]    pwdata_i, prdata_o, seed;
  logic [DW-1:0]  adc, val, y1, y2, res;
  logic [2:0]     range_o, tgt;
  trmsq_disp_type msg;
  logic [64:0]    aq[$];
  logic [DW:0]    dq[$];
  int             err_count, tests_run, cyc, n;

  trmsq_top #(.DW(DW), .READ_CYC(RC), .SAMPLE_CYC(SC), .HOLD_CYC(HC)) dut
  (
    .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .mode_key_i(mode_key_i),
    .adc_data_i(adc), .adc_over_i(ovr), .adc_under_i(und), .range_o(range_o),
    .hold_o(hold_o), .sh_feed_o(feed), .disp_msg_o(msg), .disp_value_o(val),
    .disp_plus_o(plus), .sample_ind_o(ind), .ac_volts_function_o(ac), .dc_volts_function_o(dc)
  );
  trmsq_conv_model #(.DW(DW)) u_conv
  (
    .range_i(range_o), .sh_feed_i(feed), .tgt_i(tgt), .y1_i(y1), .y2_i(y2),
    .adc_data_o(adc), .over_o(ovr), .under_o(und)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask

  task automatic summarize();
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // APB transfer; the expected answer is queued for the monitor
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] e, input logic er);
    aq.push_back({er, m, e});
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Wait for the answer; only the bench timeout ends a hung transfer
    do
      @(posedge clk_i);
    while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_msg(input trmsq_disp_type m, input int lim);
    int k;
    k = 0;
    while (msg !== m && k < lim)
    begin
      @(posedge clk_i);
      k++;
    end
    chk(msg === m, "display message");
  endtask

  // Cycles until the sample lamp next toggles
  task automatic gap(output int k);
    logic s;
    s = ind;
    k = 0;
    while (ind === s && k < 1000)
    begin
      @(posedge clk_i);
      k++;
    end
  endtask

  task automatic press();
    mode_key_i <= 1'b1;
    @(posedge clk_i);
    mode_key_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Monitor: oldest noted answer against what the design shows
  always @(posedge clk_i)
  begin
    logic [64:0] e;
    logic [DW:0] r;
    cyc++;
    if (psel_i && penable_i && pready_o === 1'b1 && aq.size() > 0)
    begin
      e = aq.pop_front();
      chk(pslverr_o === e[64] && (prdata_o & e[63:32]) === e[31:0], "apb answer");
    end
    if (nrst_i === 1'b1 && ind !== ind_q && dq.size() > 0)
    begin
      r = dq.pop_front();
      chk(val === r[DW-1:0] && plus === r[DW] && msg === disp_read, "reading");
    end
    ind_q = ind;
    if (cyc == 5000)
    begin
      chk(1'b0, "timeout");
      summarize();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    nrst_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    mode_key_i = 1'b0;
    seed = lfsr(32'hA250);
    y1 = 16'h2000 + {4'h0, seed[11:0]};
    y2 = y1 - {12'h000, seed[15:12]} - 16'h0001;
    tgt = seed[18:16];
    res = (y1 << 1) - y2;
    repeat (6) @(posedge clk_i);
    chk(range_o === 3'h7 && msg === disp_blank && hold_o === 1'b0 && ac === 1'b0, "reset");
    nrst_i <= 1'b1;
    @(posedge clk_i);
    apb(1'b0, 12'h00C, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1);
    apb(1'b1, 12'h000, 32'h7, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 12'h004, 32'h0, 32'h1, 32'h1, 1'b0);
    apb(1'b0, 12'h000, 32'h0, 32'h11F, 32'h0, 1'b0);
    // Function on: autorange from 500 V down to the signal
    apb(1'b1, 12'h000, 32'h3, 32'h0, 32'h0, 1'b0);
    dq.push_back({1'b0, y1});
    if (tgt != 3'h7)
      wait_msg(disp_range, 2 * RC);
    wait_msg(disp_read, 9 * RC);
    chk(range_o === tgt && ac === 1'b1 && dc === 1'b1, "fast");
    gap(n);
    chk(n >= RC - 2 && n <= RC + 2, "fast rate");
    apb(1'b0, 12'h004, 32'h0, 32'h1C6, {23'h0, tgt, 6'h00}, 1'b0);
    // Fast enhanced: banner through the reference cycle
    press();
    chk(msg === disp_faste_banner && range_o === tgt, "enhanced entry");
    dq.push_back({1'b1, res});
    dq.push_back({1'b1, res});
    repeat (SC + 5) @(posedge clk_i);
    chk(msg === disp_faste_banner && hold_o === 1'b1 && feed === 1'b1, "reference");
    wait_msg(disp_read, HC + RC + 10);
    gap(n);
    chk(n >= RC - 2 && n <= RC + 2, "enhanced rate");
    // Drift beyond one percent while tracking forces a new reference cycle
    res = ((y1 + 16'h0100) << 1) - y2;
    y1 <= y1 + 16'h0100;
    dq.push_back({1'b1, res});
    repeat (RC + SC + 10) @(posedge clk_i);
    chk(hold_o === 1'b1 && msg === disp_read, "re-reference");
    gap(n);
    // High accuracy: sample then hold, result at end of each cycle
    press();
    chk(msg === disp_precision_mode_banner && range_o === tgt && hold_o === 1'b0, "precise");
    dq.push_back({1'b0, res});
    dq.push_back({1'b0, res});
    gap(n);
    chk(n >= SC + HC - 3 && n <= SC + HC + 3, "first result");
    gap(n);
    chk(n >= SC + HC - 3 && n <= SC + HC + 3, "cycle rate");
    press();
    apb(1'b0, 12'h004, 32'h0, 32'h1C6, {23'h0, tgt, 6'h00}, 1'b0);
    // Manual range follows control at once and survives a mode step
    apb(1'b1, 12'h000, 32'hB3, 32'h0, 32'h0, 1'b0);
    repeat (2) @(posedge clk_i);
    chk(range_o === 3'h5, "manual");
    press();
    chk(range_o === 3'h5, "manual kept");
    chk(aq.size() == 0 && dq.size() == 0, "pending");
    summarize();
  end
endmodule
